// *** core/nbs_pkg.sv ***
// Shared types and constants of the nibble bus cycle sequencer.
package nbs_pkg;
	localparam int unsigned CLK_HZ_DEF  = 40_000_000;
	localparam int unsigned SYS_HZ_DEF  = 750_000;
	localparam int unsigned PH_PER_CYC  = 8;
	localparam int unsigned IDX_WORDS   = 16;
	localparam int unsigned STK_WORDS   = 4;
	localparam logic [11:0] RST_PC      = 12'h000;
	localparam logic [3:0]  RST_BANK    = 4'h1;
	localparam logic [1:0]  RST_PTR     = 2'h0;
	localparam logic [3:0]  RST_NIBBLE  = 4'h0;
	localparam logic [3:0]  BUS_ALL     = 4'hf;
	localparam logic [3:0]  BUS_NONE    = 4'h0;
	localparam logic [3:0]  RF_LAST     = 4'hf;

	// Eight bus phases of one instruction cycle.
	typedef enum logic [2:0] {
		NBS_ADDR1, NBS_ADDR2, NBS_ADDR3, NBS_FETCH1, NBS_FETCH2,
		NBS_EXEC1, NBS_EXEC2, NBS_EXEC3
	} nbs_phase_t;

	// Data bus pins: value and enable per line.
	typedef struct packed {
		logic [3:0] dout;
		logic [3:0] oe;
	} nbs_pin_t;

	// Five command lines.
	typedef struct packed {
		logic       prog;
		logic [3:0] bank;
	} nbs_cmd_t;

	// Fetched instruction word.
	typedef struct packed {
		logic [3:0] opcode_nibble;
		logic [3:0] modifier_nibble;
	} nbs_instr_t;

	// Requests from the instruction decoder, on the same clock.
	typedef struct packed {
		logic        two_word;
		logic        subroutine_call;
		logic        ret;
		logic        jump;
		logic [11:0] target;
		logic        port_wr;
		logic        port_rd;
		logic        mem_wr;
		logic        send_addr;
		logic [2:0]  pair;
		logic [3:0]  acc;
		logic        idx_we;
		logic [3:0]  idx_addr;
		logic [3:0]  idx_wdata;
		logic        bank_ld;
		logic [1:0]  bank_sel;
	} nbs_ctl_t;
endpackage : nbs_pkg

// *** core/nbs_sequencer.sv ***
// Instruction-cycle sequencer with address stack and index array.
// What this block does
// RULE1 - Cycle-start marker every eight phases.
// RULE2 - Instructions take one or two cycles.
// RULE3 - Address sent as three slices first.
// RULE4 - Memories decode chip and word from address; the model takes the word from address bits 7:0 and decodes no chip.
// RULE5 - Memory returns opcode then modifier nibble.
// RULE6 - Execute in the last three phases.
// RULE7 - Port data exchanged in execute phase two.
// RULE8 - Pair address sent in execute two, three.
// RULE9 - Accumulator sent on data memory output.
// RULE10 - One program and four bank command lines.
// RULE11 - Reset clears state, starts at zero, bank0.
// RULE12 - One driver per line, others float.
// RULE13 - Memories time themselves from the marker.
// RULE14 - Four 12-bit words: counter plus stack.
// RULE15 - Slice incremented after each slice leaves.
// RULE16 - Index array as nibbles or pairs.
// RULE17 - Writes via holding register, reads via mux.
// RULE18 - Index decoder alternates bus and refresh.
// RULE19 - Even register upper, odd register lower.
// RULE20 - Long reset lets refresh visit everything; the code runs the refresh sweep after release instead.
// RULE21 - Opcode first fetch, modifier second fetch.
// RULE22 - Call pushes; fourth call loses oldest.
// RULE23 - Phase steps per period, wraps with marker.
`timescale 1ns/10ps
`default_nettype none
module nbs_sequencer
	import nbs_pkg::*;
#(
	parameter int unsigned CLK_HZ = CLK_HZ_DEF,
	parameter int unsigned SYS_HZ = SYS_HZ_DEF
) (
	input  wire logic       i_clk,
	input  wire logic       i_rst_b,
	input  wire logic [3:0] i_bus_in,
	input  wire nbs_ctl_t   i_ctl,
	output nbs_pin_t        o_bus,
	output logic            o_sync,
	output nbs_cmd_t        o_cmd,
	output nbs_phase_t      o_phase,
	output nbs_instr_t      o_instr,
	output logic            o_second_word,
	output logic [3:0]      o_port_data,
	output logic [3:0]      o_idx_rdata
);
	localparam int unsigned DIV_CYC = CLK_HZ / SYS_HZ;
	localparam logic [7:0]  DIV_LAST = 8'(DIV_CYC - 1);

	// A phase must last three clocks or more, because the bus reaches the
	// sampling point two flip-flops late and must show the new phase by then.
	if (DIV_CYC < 3 || DIV_CYC > 256) begin : g_bad_div
		$error("nbs_sequencer: clock ratio out of range");
	end

	// Four-bit carry look-ahead increment of one address slice.
	function automatic logic [4:0] inc_slice(input logic [3:0] a, input logic ci);
		logic [3:0] c;
		c[0] = ci;
		c[1] = ci & a[0];
		c[2] = ci & a[0] & a[1];
		c[3] = ci & a[0] & a[1] & a[2];
		return {ci & (&a), a ^ c};
	endfunction : inc_slice

	logic [11:0] stk_mem [STK_WORDS];
	logic [3:0]  idx_mem [IDX_WORDS];
	logic [3:0]  bus_s1_q, bus_s2_q;
	logic [7:0]  div_q, div_d;
	nbs_phase_t  ph_q, ph_d;
	logic        en;
	logic [11:0] abuf_q, abuf_d;
	logic        cy_q, cy_d;
	logic [1:0]  ptr_q, ptr_d;
	logic        second_q, second_d;
	logic [3:0]  bank_q, bank_d;
	nbs_pin_t    bus_q, bus_d;
	nbs_cmd_t    cmd_q, cmd_d;
	logic        sync_q, sync_d;
	nbs_instr_t  ins_q, ins_d;
	logic [3:0]  port_q, port_d;
	logic        stk_we;
	logic [1:0]  stk_wa;
	logic [11:0] stk_wd;
	logic        tmp_v_q, tmp_v_d;
	logic [3:0]  tmp_a_q, tmp_a_d, tmp_w_q, tmp_w_d;
	logic        slot_q, slot_d;
	logic [3:0]  rf_q, rf_d;
	logic        clr_q, clr_d;
	logic [3:0]  rd_q, rd_d;
	logic        idx_we;
	logic [3:0]  idx_wa, idx_wd;
	logic        stk_clr;

	// Bus pins come from other chips, so they pass two flip-flops first.
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			bus_s1_q <= RST_NIBBLE;
			bus_s2_q <= RST_NIBBLE;
		end else begin
			bus_s1_q <= i_bus_in;
			bus_s2_q <= bus_s1_q;
		end
	end

	// Phase sequencing, address slicing, fetch and execute bus traffic.
	always_comb begin
		div_d    = (div_q == DIV_LAST) ? 8'h00 : div_q + 8'h01;
		en       = (div_q == DIV_LAST) && !clr_q;
		ph_d     = ph_q;
		abuf_d   = abuf_q;
		cy_d     = cy_q;
		ptr_d    = ptr_q;
		second_d = second_q;
		bank_d   = bank_q;
		bus_d    = bus_q;
		cmd_d    = cmd_q;
		sync_d   = sync_q;
		ins_d    = ins_q;
		port_d   = port_q;
		stk_we   = 1'b0;
		stk_wa   = ptr_q;
		stk_wd   = abuf_q;
		if (i_ctl.bank_ld) begin
			bank_d = 4'h1 << i_ctl.bank_sel;
		end
		if (en) begin
			ph_d = (ph_q == NBS_EXEC3) ? NBS_ADDR1 : ph_q.next(); // RULE23
			unique case (ph_q)
				NBS_ADDR1: begin
					{cy_d, abuf_d[3:0]} = inc_slice(abuf_q[3:0], 1'b1); // RULE15
				end
				NBS_ADDR2: begin
					{cy_d, abuf_d[7:4]} = inc_slice(abuf_q[7:4], cy_q); // RULE15
				end
				NBS_ADDR3: begin
					{cy_d, abuf_d[11:8]} = inc_slice(abuf_q[11:8], cy_q); // RULE15
					stk_we = 1'b1;
					stk_wd = abuf_d; // RULE15
				end
				NBS_FETCH1: begin
					ins_d.opcode_nibble = bus_s2_q; // RULE21
				end
				NBS_FETCH2: begin
					ins_d.modifier_nibble = bus_s2_q; // RULE21
				end
				NBS_EXEC1: begin
				end
				NBS_EXEC2: begin // RULE6
					if (i_ctl.port_rd) begin
						port_d = bus_s2_q; // RULE7
					end
				end
				NBS_EXEC3: begin
					// The target is carried by the second word, so flow changes there.
					second_d = i_ctl.two_word && !second_q; // RULE2
					if (second_q && i_ctl.subroutine_call) begin
						ptr_d  = ptr_q + 2'h1; // RULE22
						stk_we = 1'b1;
						stk_wa = ptr_d;
						stk_wd = i_ctl.target; // RULE14
					end else if (second_q && i_ctl.jump) begin
						stk_we = 1'b1;
						stk_wd = i_ctl.target;
					end else if (i_ctl.ret) begin
						ptr_d = ptr_q - 2'h1; // RULE14
					end
					abuf_d = stk_we ? stk_wd : stk_mem[ptr_d];
				end
			endcase
			// Drive for the phase being entered; all other times float.
			bus_d.oe   = BUS_NONE; // RULE12
			bus_d.dout = RST_NIBBLE;
			cmd_d      = '0;
			sync_d     = (ph_d == NBS_ADDR1); // RULE1
			unique case (ph_d)
				NBS_ADDR1: begin
					bus_d = '{dout: abuf_d[3:0], oe: BUS_ALL}; // RULE3
				end
				NBS_ADDR2: begin
					bus_d = '{dout: abuf_d[7:4], oe: BUS_ALL}; // RULE3
				end
				NBS_ADDR3: begin
					bus_d     = '{dout: abuf_d[11:8], oe: BUS_ALL}; // RULE3
					cmd_d.prog = 1'b1; // RULE10
				end
				NBS_EXEC2: begin
					if (i_ctl.port_wr || i_ctl.mem_wr) begin
						bus_d = '{dout: i_ctl.acc, oe: BUS_ALL}; // RULE9
					end else if (i_ctl.send_addr) begin
						bus_d = '{dout: idx_mem[{i_ctl.pair, 1'b0}], oe: BUS_ALL}; // RULE19
					end
					cmd_d.prog = i_ctl.port_wr || i_ctl.port_rd; // RULE7
					if (i_ctl.mem_wr || i_ctl.send_addr) begin
						cmd_d.bank = bank_d; // RULE10
					end
				end
				NBS_EXEC3: begin
					if (i_ctl.send_addr) begin
						bus_d = '{dout: idx_mem[{i_ctl.pair, 1'b1}], oe: BUS_ALL}; // RULE8
					end
				end
				default: begin
				end
			endcase
		end
	end

	// Registers of the sequencer; reset starts at address zero, bank zero.
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			div_q    <= 8'h00;
			ph_q     <= NBS_EXEC3; // RULE11
			abuf_q   <= RST_PC; // RULE11
			cy_q     <= 1'b0;
			ptr_q    <= RST_PTR;
			second_q <= 1'b0;
			bank_q   <= RST_BANK; // RULE11
			bus_q    <= '0;
			cmd_q    <= '0;
			sync_q   <= 1'b0;
			ins_q    <= '0;
			port_q   <= RST_NIBBLE;
		end else begin
			div_q    <= div_d;
			ph_q     <= ph_d;
			abuf_q   <= abuf_d;
			cy_q     <= cy_d;
			ptr_q    <= ptr_d;
			second_q <= second_d;
			bank_q   <= bank_d;
			bus_q    <= bus_d;
			cmd_q    <= cmd_d;
			sync_q   <= sync_d;
			ins_q    <= ins_d;
			port_q   <= port_d;
		end
	end

	// Index array access: even clocks serve the bus, odd clocks the refresh
	// counter. A new write request in a bus slot is held while the old one retires; in a refresh slot it replaces the held one.
	always_comb begin
		slot_d  = !slot_q; // RULE18
		rf_d    = rf_q;
		clr_d   = clr_q;
		tmp_v_d = tmp_v_q;
		tmp_a_d = tmp_a_q;
		tmp_w_d = tmp_w_q;
		rd_d    = rd_q;
		idx_we  = 1'b0;
		idx_wa  = tmp_a_q;
		idx_wd  = tmp_w_q;
		stk_clr = 1'b0;
		if (!slot_q) begin
			rd_d = idx_mem[i_ctl.idx_addr]; // RULE17
			if (tmp_v_q) begin
				idx_we  = 1'b1; // RULE17
				tmp_v_d = 1'b0;
			end
		end else begin
			rf_d = rf_q + 4'h1; // RULE18
			if (clr_q) begin
				idx_we  = 1'b1; // RULE20
				idx_wa  = rf_q;
				idx_wd  = RST_NIBBLE;
				stk_clr = 1'b1;
				clr_d   = (rf_q != RF_LAST);
			end
		end
		if (i_ctl.idx_we) begin
			tmp_v_d = 1'b1; // RULE17
			tmp_a_d = i_ctl.idx_addr;
			tmp_w_d = i_ctl.idx_wdata;
		end
	end

	// The sweep after release clears both arrays before the first cycle.
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			slot_q  <= 1'b0;
			rf_q    <= RST_NIBBLE;
			clr_q   <= 1'b1; // RULE11
			tmp_v_q <= 1'b0;
			tmp_a_q <= RST_NIBBLE;
			tmp_w_q <= RST_NIBBLE;
			rd_q    <= RST_NIBBLE;
		end else begin
			slot_q  <= slot_d;
			rf_q    <= rf_d;
			clr_q   <= clr_d;
			tmp_v_q <= tmp_v_d;
			tmp_a_q <= tmp_a_d;
			tmp_w_q <= tmp_w_d;
			rd_q    <= rd_d;
		end
	end

	// Storage arrays carry no reset, like the dynamic cells they stand for.
	always_ff @(posedge i_clk) begin
		if (idx_we) begin
			idx_mem[idx_wa] <= idx_wd; // RULE16
		end
		if (stk_clr) begin
			stk_mem[rf_q[1:0]] <= RST_PC; // RULE14
		end else if (stk_we) begin
			stk_mem[stk_wa] <= stk_wd; // RULE14
		end
	end

	assign o_bus         = bus_q;
	assign o_sync        = sync_q;
	assign o_cmd         = cmd_q;
	assign o_phase       = ph_q;
	assign o_instr       = ins_q;
	assign o_second_word = second_q;
	assign o_port_data   = port_q;
	assign o_idx_rdata   = rd_q;

	// Clocks since the last marker rose; it rests at zero until the first marker,
	// because the sweep after reset makes the first cycle start late.
	logic [15:0] since_q;
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			since_q <= 16'h0000;
		end else begin
			since_q <= (sync_d && !sync_q) ? 16'h0001 :
				(since_q == 16'h0000) ? 16'h0000 : since_q + 16'h0001;
		end
	end

	chk_sync_period: assert property (@(posedge i_clk) disable iff (!i_rst_b) // RULE1
		$rose(o_sync) && $past(since_q) != 16'h0000 |->
			$past(since_q) == 16'(PH_PER_CYC * DIV_CYC))
		else $error("marker period is not eight phases");
	chk_sync_phase: assert property (@(posedge i_clk) disable iff (!i_rst_b) // RULE23
		o_sync |-> o_phase == NBS_ADDR1)
		else $error("marker outside the first address phase");
	chk_addr_drive: assert property (@(posedge i_clk) disable iff (!i_rst_b) // RULE3
		(o_phase inside {NBS_ADDR1, NBS_ADDR2, NBS_ADDR3}) && !clr_q |->
			o_bus.oe == BUS_ALL)
		else $error("address phase without bus drive");
	chk_fetch_float: assert property (@(posedge i_clk) disable iff (!i_rst_b) // RULE12
		o_phase inside {NBS_FETCH1, NBS_FETCH2, NBS_EXEC1} |-> o_bus.oe == BUS_NONE)
		else $error("bus driven while memory owns it");
	chk_opcode_latch: assert property (@(posedge i_clk) disable iff (!i_rst_b) // RULE21
		en && ph_q == NBS_FETCH1 |=> o_instr.opcode_nibble == $past(bus_s2_q))
		else $error("opcode nibble not taken in first fetch phase");
	chk_prog_cmd: assert property (@(posedge i_clk) disable iff (!i_rst_b) // RULE10
		o_cmd.prog |-> o_phase inside {NBS_ADDR3, NBS_EXEC2})
		else $error("program command line out of its phases");
	chk_bank_onehot: assert property (@(posedge i_clk) disable iff (!i_rst_b) // RULE10
		$onehot(bank_q) && (o_cmd.bank == BUS_NONE || o_phase == NBS_EXEC2))
		else $error("bank command lines malformed");
	chk_addr_incr: assert property (@(posedge i_clk) disable iff (!i_rst_b) // RULE15
		en && ph_q == NBS_ADDR3 |=> stk_mem[ptr_q] == $past(stk_mem[ptr_q]) + 12'h001)
		else $error("program address not incremented by one");
	chk_second_word: assert property (@(posedge i_clk) disable iff (!i_rst_b) // RULE2
		$rose(o_second_word) |-> o_phase == NBS_ADDR1 ##1 o_second_word[*8])
		else $error("second word not aligned to a whole cycle");
endmodule : nbs_sequencer
`default_nettype wire

// *** verif/nbs_mem_model.sv ***
// Behavioural program and data memory chips on the far side of the nibble bus.
`timescale 1ns/10ps
`default_nettype none
module nbs_mem_model
	import nbs_pkg::*;
#(
	parameter int PH = 4
) (
	input  wire logic       i_clk,
	input  wire logic       i_rst_b,
	input  wire logic [3:0] i_bus,
	input  wire logic       i_sync,
	input  wire nbs_cmd_t   i_cmd,
	input  wire logic       i_port_in_en,
	input  wire logic [3:0] i_port_in,
	output logic [3:0]      o_dout,
	output logic [3:0]      o_oe,
	output logic [3:0]      o_port_out,
	output logic [3:0]      o_ram_out
);
	logic [7:0]  cnt_q;
	logic        sync_q;
	logic [11:0] adr_q;
	logic [7:0]  word;
	logic        last;
	int          ph;

	// Phase is counted from the marker only, so a wrong marker shows up as bad fetches.
	assign ph   = int'(cnt_q) / PH;
	assign last = (int'(cnt_q) % PH) == PH - 1;
	assign word = adr_q[7:0] ^ 8'h3c;

	// Fetch nibbles and port input are driven only in their own phases.
	always_comb begin
		o_oe = 4'h0;
		o_dout = i_port_in;
		if (ph == 3 || ph == 4) begin
			o_oe = 4'hf;
			o_dout = (ph == 3) ? word[7:4] : word[3:0];
		end else if (ph == 6 && i_cmd.prog && i_port_in_en) begin
			o_oe = 4'hf;
		end
	end

	// Address slices, port output and data memory output are latched at phase ends.
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cnt_q <= 8'hff;
			sync_q <= 1'b0;
			adr_q <= 12'h000;
			o_port_out <= 4'h0;
			o_ram_out <= 4'h0;
		end else begin
			sync_q <= i_sync;
			if (i_sync && !sync_q) begin
				cnt_q <= 8'h01;
			end else if (cnt_q != 8'hff) begin
				cnt_q <= cnt_q + 8'h01;
			end
			if (last && ph < 3) begin
				adr_q[ph*4 +: 4] <= i_bus;
			end
			if (last && ph == 6 && o_oe == 4'h0) begin
				if (i_cmd.prog) begin
					o_port_out <= i_bus;
				end
				if (i_cmd.bank != 4'h0) begin
					o_ram_out <= i_bus;
				end
			end
		end
	end
endmodule : nbs_mem_model
`default_nettype wire

// *** verif/nibble_bus_cycle_sequencer_tb.sv ***
// Self-checking bench of the nibble bus cycle sequencer with its memory partner.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
	$display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module nibble_bus_cycle_sequencer_tb;
	import nbs_pkg::*;
	localparam int P = 4;
	logic       clk = 1'b0;
	logic       rst_b = 1'b0;
	logic [3:0] bus;
	logic [3:0] flt = 4'h5;
	nbs_ctl_t   ctl = '0;
	nbs_pin_t   pin;
	nbs_cmd_t   cmd;
	nbs_phase_t phase;
	nbs_instr_t instr;
	logic       sync, sw2, port_en = 1'b0;
	logic [3:0] port_d, idx_d, m_dout, m_oe, port_out, ram_out, port_in = 4'h0;
	int         n_fail = 0, n_tests = 0, cycles = 0;

	// Undriven lines toggle each clock so a stale value is never read as valid.
	assign bus = (pin.oe & pin.dout) | (~pin.oe & m_oe & m_dout) | (~pin.oe & ~m_oe & flt);
	always #12.5 clk = ~clk;
	always @(posedge clk) flt <= ~flt;

	nbs_sequencer #(.CLK_HZ(4), .SYS_HZ(1)) i_nbs_sequencer (.i_clk(clk), .i_rst_b(rst_b),
		.i_bus_in(bus), .i_ctl(ctl), .o_bus(pin), .o_sync(sync), .o_cmd(cmd), .o_phase(phase),
		.o_instr(instr), .o_second_word(sw2), .o_port_data(port_d), .o_idx_rdata(idx_d));
	nbs_mem_model #(.PH(P)) i_nbs_mem_model (.i_clk(clk), .i_rst_b(rst_b), .i_bus(bus),
		.i_sync(sync), .i_cmd(cmd), .i_port_in_en(port_en), .i_port_in(port_in),
		.o_dout(m_dout), .o_oe(m_oe), .o_port_out(port_out), .o_ram_out(ram_out));

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : report_and_stop

	// One whole cycle, entered and left on the first falling edge of the first address phase.
	task automatic cyc(input logic [11:0] pc, input logic sw, input logic [3:0] x2oe,
		input logic [3:0] x2d, input logic [4:0] x2c, input logic [3:0] x3oe, x3d);
		for (int k = 0; k < 8; k++) begin
			`CHK("phase", 3'(k), 3'(phase))
			`CHK("marker", k == 0, sync)
			if (k < 3) `CHK("addr", {4'hf, pc[k*4 +: 4]}, {pin.oe, pin.dout})
			if (k == 0) `CHK("second", sw, sw2)
			if (k == 2) `CHK("prog_a3", 5'h10, cmd)
			if (k == 3 || k == 4) `CHK("float", 4'h0, pin.oe)
			if (k == 5) `CHK("instr", pc[7:0] ^ 8'h3c, instr)
			if (k == 6) `CHK("x2", {x2oe, x2c}, {pin.oe, cmd})
			if (k == 6 && x2oe != 0) `CHK("x2d", x2d, pin.dout)
			if (k == 7) `CHK("x3", x3oe, pin.oe)
			if (k == 7 && x3oe != 0) `CHK("x3d", x3d, pin.dout)
			repeat (P) @(negedge clk);
		end
	endtask : cyc

	task automatic t_reset();
		`CHK("rst_oe", 4'h0, pin.oe)
		`CHK("rst_cmd", 5'h00, cmd)
		`CHK("rst_ph", 3'(NBS_EXEC3), 3'(phase))
		rst_b = 1'b1;
		@(posedge sync);
		@(negedge clk);
		cyc(12'h000, 0, 4'h0, 4'h0, 5'h00, 4'h0, 4'h0);
		$display("test reset done");
	endtask : t_reset

	// Writes are spaced so each one retires from the holding register first.
	task automatic t_idx();
		ctl.idx_we = 1'b1;
		ctl.idx_addr = 4'h4;
		ctl.idx_wdata = 4'h3;
		@(negedge clk);
		ctl.idx_we = 1'b0;
		repeat (3) @(negedge clk);
		ctl.idx_we = 1'b1;
		ctl.idx_addr = 4'h5;
		ctl.idx_wdata = 4'h7;
		@(negedge clk);
		ctl.idx_we = 1'b0;
		ctl.idx_addr = 4'h4;
		repeat (4) @(negedge clk);
		`CHK("idx4", 4'h3, idx_d)
		ctl.idx_addr = 4'h5;
		repeat (4) @(negedge clk);
		`CHK("idx5", 4'h7, idx_d)
		@(posedge sync);
		@(negedge clk);
		$display("test index done");
	endtask : t_idx

	task automatic t_io();
		ctl = '{port_wr: 1'b1, acc: 4'ha, default: '0};
		cyc(12'h002, 0, 4'hf, 4'ha, 5'h10, 4'h0, 4'h0);
		`CHK("port_out", 4'ha, port_out)
		ctl = '{mem_wr: 1'b1, acc: 4'h6, default: '0};
		cyc(12'h003, 0, 4'hf, 4'h6, 5'h01, 4'h0, 4'h0);
		`CHK("ram_out", 4'h6, ram_out)
		ctl = '{send_addr: 1'b1, pair: 3'h2, bank_ld: 1'b1, bank_sel: 2'h2, default: '0};
		cyc(12'h004, 0, 4'hf, 4'h3, 5'h04, 4'hf, 4'h7);
		ctl = '{port_rd: 1'b1, default: '0};
		port_en = 1'b1;
		port_in = 4'h9;
		cyc(12'h005, 0, 4'h0, 4'h0, 5'h10, 4'h0, 4'h0);
		port_en = 1'b0;
		`CHK("port_in", 4'h9, port_d)
		$display("test ports done");
	endtask : t_io

	// Jump, carry across slices, a call and its return.
	task automatic t_flow();
		ctl = '{two_word: 1'b1, default: '0};
		cyc(12'h006, 0, 4'h0, 4'h0, 5'h00, 4'h0, 4'h0);
		ctl = '{jump: 1'b1, target: 12'h2ff, default: '0};
		cyc(12'h007, 1, 4'h0, 4'h0, 5'h00, 4'h0, 4'h0);
		ctl = '{two_word: 1'b1, default: '0};
		cyc(12'h2ff, 0, 4'h0, 4'h0, 5'h00, 4'h0, 4'h0);
		ctl = '{subroutine_call: 1'b1, target: 12'h123, default: '0};
		cyc(12'h300, 1, 4'h0, 4'h0, 5'h00, 4'h0, 4'h0);
		ctl = '{ret: 1'b1, default: '0};
		cyc(12'h123, 0, 4'h0, 4'h0, 5'h00, 4'h0, 4'h0);
		ctl = '0;
		cyc(12'h301, 0, 4'h0, 4'h0, 5'h00, 4'h0, 4'h0);
		$display("test flow done");
	endtask : t_flow

	// Reset held for eight whole cycles in mid-run must clear the index array
	// and bring the address and the bank line back to their starting values.
	task automatic t_rerst();
		ctl = '{idx_addr: 4'h4, default: '0};
		rst_b = 1'b0;
		repeat (8 * 8 * P) @(negedge clk);
		`CHK("rst_sync", 1'b0, sync)
		`CHK("rst_oe2", 4'h0, pin.oe)
		rst_b = 1'b1;
		@(posedge sync);
		@(negedge clk);
		`CHK("idx_clear", 4'h0, idx_d)
		ctl = '{mem_wr: 1'b1, acc: 4'h5, idx_addr: 4'h4, default: '0};
		cyc(12'h000, 0, 4'hf, 4'h5, 5'h01, 4'h0, 4'h0);
		`CHK("ram_out2", 4'h5, ram_out)
		$display("test mid-run reset done");
	endtask : t_rerst

	// A hang is cut short well beyond the roughly seven hundred and fifty clocks the run needs.
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			n_fail++;
			report_and_stop();
		end
	end

	initial begin
		repeat (2) @(negedge clk);
		t_reset();
		t_idx();
		t_io();
		t_flow();
		t_rerst();
		report_and_stop();
	end
endmodule : nibble_bus_cycle_sequencer_tb
`default_nettype wire
